// ### rtl/tcm_pkg.sv
// Constants shared by the capture/compare timer and its prescaler
package tcm_pkg;
	// ==================================================================
	// Register byte offsets (one aligned 32-bit word each)
	localparam logic [7:0] OFF_CTL0   = 8'h00; // Interrupt source, capture flag
	localparam logic [7:0] OFF_CTL1   = 8'h04; // Enable, polarity, prescale, mode
	localparam logic [7:0] OFF_CNTH   = 8'h08; // Counter high byte
	localparam logic [7:0] OFF_CNTL   = 8'h0c; // Counter low byte
	localparam logic [7:0] OFF_RLDH   = 8'h10; // Reload/compare high byte
	localparam logic [7:0] OFF_RLDL   = 8'h14; // Reload/compare low byte
	localparam logic [7:0] OFF_CAPH   = 8'h18; // Capture high byte
	localparam logic [7:0] OFF_CAPL   = 8'h1c; // Capture low byte
	localparam logic [7:0] OFF_ISTAT  = 8'h20; // Sticky event status, write one to clear
	localparam logic [7:0] OFF_IMASK  = 8'h24; // Interrupt mask, same layout
	// ==================================================================
	// Field positions
	localparam int CTL0_FLAG_BIT  = 7;    // Input capture flag
	localparam int CTL0_CFG_LSB   = 5;    // Interrupt source config [6:5]
	localparam int CTL1_EN_BIT    = 7;    // Timer enable
	localparam int CTL1_POL_BIT   = 6;    // Edge polarity select
	localparam int CTL1_PRE_LSB   = 3;    // Prescale exponent [5:3]
	localparam int CTL1_MODE_LSB  = 0;    // Mode [1:0]
	localparam int ST_CAP_BIT     = 0;    // Capture event
	localparam int ST_RLD_BIT     = 1;    // Reload event
	localparam int ST_GATE_BIT    = 2;    // Gate deassert event
	// ==================================================================
	// Reset values and counts
	localparam logic [7:0]  CTL0_RST   = 8'h00;
	localparam logic [7:0]  CTL1_RST   = 8'h00;
	localparam logic [15:0] CNT_RST    = 16'h0001;
	localparam logic [15:0] RLD_RST    = 16'hffff;
	localparam logic [15:0] CAP_RST    = 16'h0000;
	localparam logic [2:0]  ISTAT_RST  = 3'h0;
	localparam logic [2:0]  IMASK_RST  = 3'h0;
	localparam logic [15:0] RESTART_VAL = 16'h0001; // Value after every counter reset
	// ==================================================================
	// Modes and interrupt source codes
	localparam logic [1:0] MODE_CAPRST = 2'h0;  // Capture-restart
	localparam logic [1:0] MODE_GATED  = 2'h1;  // Gated counting
	localparam logic [1:0] MODE_CAPCMP = 2'h2;  // Capture/compare
	localparam logic [1:0] CFG_BOTH    = 2'h0;  // Both sources interrupt
	localparam logic [1:0] CFG_INPUT   = 2'h2;  // Input event only
	localparam logic [1:0] CFG_RELOAD  = 2'h3;  // Reload event only
	// ==================================================================
	// Run state
	typedef enum logic [2:0] {
		ST_OFF = 3'b001,  // Disabled
		ST_ARM = 3'b010,  // Waiting for first accepted edge
		ST_RUN = 3'b100   // Counting
	} tcm_state_type;
endpackage

// ### rtl/tcm_prescaler.sv
// Power-of-two prescaler producing a one-cycle count enable
`timescale 1ns/1ps
`default_nettype none
module tcm_prescaler (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       clear,    // Restart division while timer is off
	input  wire logic [2:0] prescale, // Divide by two to this power
	output logic            tick      // Count enable pulse
);
	import tcm_pkg::*;
	logic [6:0] divCntFf;     // Division counter
	logic [6:0] divMask;      // Terminal pattern for the chosen divider
	logic       divDone;      // Terminal count reached

	assign divMask = 7'((8'h01 << prescale) - 8'h01);
	assign divDone = ((divCntFf & divMask) == divMask);

	// ==================================================================
	// Divider; division by one gives a tick every cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_n || clear) begin
			divCntFf <= 7'h00;
			tick     <= 1'b0;
		end else begin
			divCntFf <= divDone ? 7'h00 : divCntFf + 7'h01;
			tick     <= divDone;
		end
	end
endmodule // tcm_prescaler
`default_nettype wire

// ### rtl/tcm_timer.sv
// Capture-restart, gated and capture/compare timer with APB registers
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Capture-restart edge copies count to capture
// - Count from system clock, pin gives events
// - Polarity bit selects rising or falling edge
// - Capture interrupts, restarts at 0001H, keeps counting
// - Capture interrupt sets input capture flag
// - Count to reload, interrupt, restart 0001H
// - Reload in capture modes clears input capture flag
// - Capture/compare idles until first accepted edge
// - Later edges capture, interrupt, restart 0001H
// - Gated: written start only first pass
// - Gated interrupts on deassert and reload, configurable
// - Capture modes: config limits interrupt source
module tcm_timer (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        timerIn,   // Timer input pin, asynchronous
	output logic             irq        // Level interrupt
);
	import tcm_pkg::*;

	// ==================================================================
	// Declarations
	logic [7:0]    ctl0Ff;         // Config and capture flag
	logic [7:0]    ctl1Ff;         // Enable, polarity, prescale, mode
	logic [15:0]   countFf;        // Running count
	logic [15:0]   reloadFf;       // Reload/compare value
	logic [15:0]   captureFf;      // Captured count
	logic [2:0]    statFf;         // Sticky events
	logic [2:0]    maskFf;         // Interrupt mask
	tcm_state_type stateFf;        // Run state
	tcm_state_type nxt_state;
	logic          pinS1Ff;        // Synchroniser first stage
	logic          pinS2Ff;        // Synchroniser second stage
	logic          pinS3Ff;        // Previous synchronised level
	logic          tick;           // Prescaled count enable
	logic [15:0]   nxt_count;
	logic [2:0]    nxt_stat;

	// Field views
	wire        timerEn   = ctl1Ff[CTL1_EN_BIT];
	wire        edgePol   = ctl1Ff[CTL1_POL_BIT];
	wire [2:0]  preSel    = ctl1Ff[CTL1_PRE_LSB +: 3];
	wire [1:0]  modeSel   = ctl1Ff[CTL1_MODE_LSB +: 2];
	wire [1:0]  intCfg    = ctl0Ff[CTL0_CFG_LSB +: 2];
	wire        capFlag   = ctl0Ff[CTL0_FLAG_BIT];

	// ==================================================================
	// Bus decode
	wire        busAccess = psel && penable && pready;   // Completing edge
	wire        busWr     = busAccess && pwrite;
	wire        wrCtl0    = busWr && (paddr == OFF_CTL0);
	wire        wrCtl1    = busWr && (paddr == OFF_CTL1);
	wire        wrCntH    = busWr && (paddr == OFF_CNTH);
	wire        wrCntL    = busWr && (paddr == OFF_CNTL);
	wire        wrRldH    = busWr && (paddr == OFF_RLDH);
	wire        wrRldL    = busWr && (paddr == OFF_RLDL);
	wire        wrStat    = busWr && (paddr == OFF_ISTAT);
	wire        wrMask    = busWr && (paddr == OFF_IMASK);
	wire        swCntWr   = wrCntH || wrCntL;
	wire [7:0]  wrByte    = pwdata[7:0];
	// Mask as it stands after this edge, so the interrupt never lags a mask write
	wire [2:0]  nxt_mask  = wrMask ? wrByte[2:0] : maskFf;

	// Read mux; capture registers are read-only, other holes read zero
	function automatic logic [7:0] read_mux(input logic [7:0] a);
		case (a)
			OFF_CTL0:  read_mux = ctl0Ff;
			OFF_CTL1:  read_mux = ctl1Ff;
			OFF_CNTH:  read_mux = countFf[15:8];
			OFF_CNTL:  read_mux = countFf[7:0];
			OFF_RLDH:  read_mux = reloadFf[15:8];
			OFF_RLDL:  read_mux = reloadFf[7:0];
			OFF_CAPH:  read_mux = captureFf[15:8];
			OFF_CAPL:  read_mux = captureFf[7:0];
			OFF_ISTAT: read_mux = {5'h00, statFf};
			OFF_IMASK: read_mux = {5'h00, maskFf};
			default:   read_mux = 8'h00;
		endcase
	endfunction

	// Word-aligned offsets up to the mask register are mapped
	wire        mapped    = (paddr[1:0] == 2'h0) && (paddr <= OFF_IMASK);

	// ==================================================================
	// Pin synchroniser and edge detection
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pinS1Ff <= 1'b0;
			pinS2Ff <= 1'b0;
			pinS3Ff <= 1'b0;
		end else begin
			pinS1Ff <= timerIn;
			pinS2Ff <= pinS1Ff;
			pinS3Ff <= pinS2Ff;
		end
	end

	// Edge register resets low; a high pin gives a false rise after reset, but the
	// timer is still off then, so that edge has nothing to act on
	wire pinRise    = pinS2Ff && !pinS3Ff;
	wire pinFall    = !pinS2Ff && pinS3Ff;
	wire acceptEdge = edgePol ? pinFall : pinRise;
	// Gate is active at the level the polarity bit names as asserted
	wire gateLevel  = edgePol ? !pinS2Ff : pinS2Ff;
	wire gateDrop   = edgePol ? pinRise : pinFall;

	// ==================================================================
	// Prescaler; held clear while the timer is off so the first tick is aligned
	tcm_prescaler u_pre (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.clear    (stateFf == ST_OFF),
		.prescale (preSel),
		.tick     (tick)
	);

	// ==================================================================
	// Event decode
	wire isGated    = (modeSel == MODE_GATED);
	wire isCapMode  = (modeSel == MODE_CAPRST) || (modeSel == MODE_CAPCMP);
	// Counter advances on the prescaled system clock only
	wire advance    = (stateFf == ST_RUN) && tick && (!isGated || gateLevel);
	wire reloadEv   = advance && (countFf == reloadFf);
	wire captureEv  = (stateFf == ST_RUN) && isCapMode && acceptEdge;
	wire gateEv     = (stateFf == ST_RUN) && isGated && gateDrop;
	// Interrupt source filter
	wire allowInp   = (intCfg != CFG_RELOAD);
	wire allowRld   = (intCfg != CFG_INPUT);

	// ==================================================================
	// Run state machine
	always_comb begin
		nxt_state = stateFf;
		case (stateFf)
			ST_OFF: begin
				if (timerEn) begin
					// Capture/compare waits for its first edge
					nxt_state = (modeSel == MODE_CAPCMP) ? ST_ARM : ST_RUN;
				end
			end
			ST_ARM: begin
				if (!timerEn) begin
					nxt_state = ST_OFF;
				end else if (acceptEdge) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!timerEn) begin
					nxt_state = ST_OFF;
				end
			end
			default: begin
				nxt_state = ST_OFF;
			end
		endcase
	end

	// ==================================================================
	// Counter next value; software write wins so setup is never lost
	always_comb begin
		nxt_count = countFf;
		if (wrCntH) begin
			nxt_count = {wrByte, countFf[7:0]};
		end else if (wrCntL) begin
			nxt_count = {countFf[15:8], wrByte};
		end else if (captureEv) begin
			nxt_count = RESTART_VAL;
		end else if (reloadEv) begin
			// Every later pass starts here, whatever software wrote first
			nxt_count = RESTART_VAL;
		end else if (advance) begin
			nxt_count = countFf + 16'h0001;
		end
	end

	// Sticky status: a new event wins over a write-one clear in the same cycle
	always_comb begin
		nxt_stat = statFf;
		if (wrStat) begin
			nxt_stat = statFf & ~wrByte[2:0];
		end
		if (captureEv && allowInp) begin
			nxt_stat[ST_CAP_BIT] = 1'b1;
		end
		if (reloadEv && allowRld) begin
			nxt_stat[ST_RLD_BIT] = 1'b1;
		end
		if (gateEv && allowInp) begin
			nxt_stat[ST_GATE_BIT] = 1'b1;
		end
	end

	// ==================================================================
	// Timer state registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			stateFf <= ST_OFF;
			countFf <= CNT_RST;
			statFf  <= ISTAT_RST;
		end else begin
			stateFf <= nxt_state;
			countFf <= nxt_count;
			statFf  <= nxt_stat;
		end
	end

	// Capture register holds the count seen at the accepted edge
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			captureFf <= CAP_RST;
		end else if (captureEv) begin
			captureFf <= countFf;
		end
	end

	// ==================================================================
	// Software registers; the capture flag is owned by hardware
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ctl0Ff   <= CTL0_RST;
			ctl1Ff   <= CTL1_RST;
			reloadFf <= RLD_RST;
			maskFf   <= IMASK_RST;
		end else begin
			if (wrCtl0) begin
				ctl0Ff[CTL0_CFG_LSB +: 2] <= wrByte[CTL0_CFG_LSB +: 2];
			end
			if (captureEv) begin
				ctl0Ff[CTL0_FLAG_BIT] <= 1'b1;
			end else if (reloadEv && isCapMode) begin
				ctl0Ff[CTL0_FLAG_BIT] <= 1'b0;
			end
			if (wrCtl1) begin
				ctl1Ff <= {wrByte[7:3], 1'b0, wrByte[1:0]};
			end
			if (wrRldH) begin
				reloadFf[15:8] <= wrByte;
			end
			if (wrRldL) begin
				reloadFf[7:0] <= wrByte;
			end
			if (wrMask) begin
				maskFf <= wrByte[2:0];
			end
		end
	end

	// ==================================================================
	// APB slave: one wait state, data and error registered with pready
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready;
			prdata  <= {24'h00_0000, read_mux(paddr)};
			pslverr <= psel && penable && !pready && !mapped;
		end
	end

	// Interrupt level from next status and next mask, so it tracks both registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(nxt_stat & nxt_mask);
		end
	end

	// ==================================================================
	// Assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence capSeen;
		captureEv && !swCntWr;
	endsequence
	sequence restartSeen;
		countFf == RESTART_VAL;
	endsequence
	// First accepted edge only starts the counter; later edges capture
	sequence armedEdge;
		stateFf == ST_ARM && timerEn && acceptEdge;
	endsequence

	cap_copy_a: assert property (captureEv |=> captureFf == $past(countFf))
		else $error("capture did not hold the count");
	cap_restart_a: assert property (capSeen |=> restartSeen)
		else $error("capture did not restart the counter");
	flag_set_a: assert property (captureEv |=> capFlag)
		else $error("capture flag not set");
	reload_wrap_a: assert property (reloadEv && !captureEv && !swCntWr |=> restartSeen)
		else $error("reload did not restart the counter");
	flag_clear_a: assert property (reloadEv && !captureEv && isCapMode |=> !capFlag)
		else $error("reload left capture flag set");
	arm_idle_a: assert property (stateFf == ST_ARM && !swCntWr |=> $stable(countFf))
		else $error("counter moved before first edge");
	edge_pick_a: assert property (acceptEdge |-> pinS2Ff == !edgePol && $past(pinS2Ff) == edgePol)
		else $error("wrong edge accepted");
	src_filter_a: assert property (intCfg == CFG_RELOAD && !statFf[ST_CAP_BIT] && !wrCtl0
		|=> !statFf[ST_CAP_BIT])
		else $error("capture status set while reload only");
	pace_tick_a: assert property (!$past(swCntWr) && $changed(countFf)
		&& countFf != RESTART_VAL |-> $past(tick))
		else $error("count moved without a tick");
	irq_level_a: assert property (|(statFf & maskFf) |-> irq)
		else $error("interrupt low with unmasked status");

	// ==================================================================
	// Status, arming, interrupt and gated restart assertions
	irq_quiet_a: assert property (!(|(statFf & maskFf)) |-> !irq)
		else $error("interrupt high with no unmasked status");
	start_edge_a: assert property (armedEdge |=> stateFf == ST_RUN)
		else $error("first edge did not start the counter");
	first_edge_a: assert property (armedEdge |=> $stable(captureFf))
		else $error("first edge overwrote the capture");
	cap_status_a: assert property (captureEv && allowInp |=> statFf[ST_CAP_BIT])
		else $error("capture status not set");
	rld_status_a: assert property (reloadEv && allowRld |=> statFf[ST_RLD_BIT])
		else $error("reload status not set");
	gate_status_a: assert property (gateEv && allowInp |=> statFf[ST_GATE_BIT])
		else $error("gate deassert status not set");
	gate_restart_a: assert property (isGated && reloadEv && !swCntWr |=> restartSeen)
		else $error("gated pass did not restart at one");
endmodule // tcm_timer
`default_nettype wire

// ### test/tcm_pin_model.sv
// Outside party that drives the timer input pin
`timescale 1ns/1ps
`default_nettype none
module tcm_pin_model (
	input  wire logic ref_clk, // System clock
	output var  logic pinLvl   // Timer input level
);
	// ==========
	// Pin state
	// The pin has no pull, so it is always driven and never left floating
	initial pinLvl = 1'b0;
	// Change level just after an edge; a gate assertion starts gated counting
	task automatic setPin(input logic lvl);
		@(posedge ref_clk);
		pinLvl <= lvl;
	endtask
endmodule // tcm_pin_model
`default_nettype wire

// ### test/tb_timer_capture_modes.sv
// Self-checking bench for the capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module tb_timer_capture_modes;
	import tcm_pkg::*;
	// ==========
	// Signals and scoreboard
	logic        ref_clk = 1'b0; // System clock, low at start
	logic        rst_n, psel, penable, pwrite, pready, pslverr, irq, timerIn;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdv;
	int          nMismatch, numChecks, seed;
	typedef struct {logic [31:0] d; logic e; bit c;} tcm_note_type;
	tcm_note_type notes[$]; // Expected answers, oldest first
	tcm_note_type cur;      // Note being compared
	tcm_timer tcm_timer_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timerIn(timerIn), .irq(irq));
	tcm_pin_model pin_i (.ref_clk(ref_clk), .pinLvl(timerIn));
	// Clock at 100 ns period
	always #50 ref_clk = ~ref_clk;
	// ==========
	// Checking tasks
	task automatic fail(input string m);
		nMismatch++;
		$display("wrong value at %0t: %s", $time, m);
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
		numChecks++;
		if (got !== exp) fail(m);
	endtask
	task automatic cmpIrq(input logic exp);
		cmp({31'h0, irq}, {31'h0, exp}, "irq level");
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", numChecks, nMismatch);
		if (nMismatch == 0 && numChecks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Second process: every completed access takes the oldest note
	always @(posedge ref_clk) begin
		if (psel && penable && pready === 1'b1) begin
			if (notes.size() == 0) fail("answer with no request");
			else begin
				cur = notes.pop_front();
				cmp({31'h0, pslverr}, {31'h0, cur.e}, "error response");
				if (cur.c && !pwrite) cmp(prdata, cur.d, "read data");
			end
		end
	end
	// ==========
	// APB master: hold the request until pready is sampled high
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
			input logic e, input bit c, input logic [31:0] x);
		int n;
		notes.push_back('{x, e, c});
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) break;
		end
		rdv = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n == 20) fail("no pready");
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d, 1'b0, 1'b0, 32'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(a, 1'b0, 32'h0, 1'b0, 1'b1, x);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// Watchdog: whole run is about a thousand cycles
	initial begin
		cyc(20000);
		fail("timeout");
		test_done;
	end
	// ==========
	// Main sequence
	initial begin
		logic [7:0] offs[10];
		logic [7:0] rstv[10];
		logic [7:0] st;
		logic [1:0] cfgs[2];
		logic [2:0] gexp[2];
		int         i;
		int         n;
		offs = '{OFF_CTL0, OFF_CTL1, OFF_CNTH, OFF_CNTL, OFF_RLDH, OFF_RLDL, OFF_CAPH,
			OFF_CAPL, OFF_ISTAT, OFF_IMASK};
		rstv = '{CTL0_RST, CTL1_RST, CNT_RST[15:8], CNT_RST[7:0], RLD_RST[15:8],
			RLD_RST[7:0], CAP_RST[15:8], CAP_RST[7:0], {5'h0, ISTAT_RST}, {5'h0, IMASK_RST}};
		cfgs = '{CFG_RELOAD, CFG_INPUT};
		gexp = '{3'h0, 3'h4};
		seed      = 88;
		nMismatch = 0;
		numChecks = 0;
		rst_n     = 1'b0;
		psel      = 1'b0;
		penable   = 1'b0;
		// Idle bus lines carry noise; the slave must ignore them while psel is low
		pwrite    = 1'($random(seed));
		paddr     = 8'($random(seed));
		pwdata    = $random(seed);
		cyc(6);
		rst_n <= 1'b1;
		// Reset values, unmapped places and the read-only capture
		for (i = 0; i < 10; i++) rd(offs[i], {24'h0, rstv[i]});
		apb(8'h28, 1'b0, 32'h0, 1'b1, 1'b1, 32'h0);
		apb(8'h02, 1'b1, $random(seed), 1'b1, 1'b0, 32'h0);
		wr(OFF_CAPL, 32'hff);
		rd(OFF_CAPL, 32'h0);
		$display("test registers done");
		// Capture-restart with each polarity, a rejected edge before the accepted one
		for (i = 0; i < 2; i++) begin
			st = 8'h10 + (8'($random(seed)) & 8'h3f);
			wr(OFF_CTL1, {24'h0, 1'b0, i[0], 3'h7, 1'b0, MODE_CAPRST});
			wr(OFF_CNTH, 32'h0);
			wr(OFF_CNTL, {24'h0, st});
			wr(OFF_RLDH, 32'hff);
			wr(OFF_RLDL, 32'hff);
			wr(OFF_IMASK, 32'h1);
			wr(OFF_ISTAT, 32'h7);
			pin_i.setPin(~i[0]);
			cyc(5);
			wr(OFF_CTL1, {24'h0, 1'b1, i[0], 3'h7, 1'b0, MODE_CAPRST});
			pin_i.setPin(i[0]);
			// Find a prescaler tick so the capture lands on a known count
			for (n = 0; n < 100; n++) begin
				apb(OFF_CNTL, 1'b0, 32'h0, 1'b0, 1'b0, 32'h0);
				if (rdv[7:0] !== st) break;
			end
			cyc(20);
			pin_i.setPin(~i[0]);
			cyc(8);
			rd(OFF_CAPL, {24'h0, st + 8'h1});
			rd(OFF_CAPH, 32'h0);
			rd(OFF_CNTL, 32'h1);
			rd(OFF_ISTAT, 32'h1);
			rd(OFF_CTL0, 32'h80);
			cmpIrq(1'b1);
			wr(OFF_ISTAT, 32'h1);
			cyc(2);
			cmpIrq(1'b0);
		end
		$display("test capture-restart done");
		// Reload at a small compare value, masked then unmasked
		wr(OFF_CTL1, {30'h0, MODE_CAPRST});
		wr(OFF_CNTL, 32'h1);
		wr(OFF_RLDH, 32'h0);
		wr(OFF_RLDL, 32'h4);
		wr(OFF_ISTAT, 32'h7);
		wr(OFF_CTL1, {24'h0, 1'b1, 5'h0, MODE_CAPRST});
		cyc(20);
		rd(OFF_ISTAT, 32'h2);
		rd(OFF_CTL0, 32'h0);
		rd(OFF_CNTH, 32'h0);
		cmpIrq(1'b0);
		wr(OFF_IMASK, 32'h2);
		cyc(2);
		cmpIrq(1'b1);
		wr(OFF_CTL0, {25'h0, CFG_INPUT, 5'h0});
		wr(OFF_ISTAT, 32'h7);
		cyc(20);
		rd(OFF_ISTAT, 32'h0);
		wr(OFF_CTL0, {25'h0, CFG_RELOAD, 5'h0});
		wr(OFF_ISTAT, 32'h7);
		pin_i.setPin(1'b1);
		cyc(8);
		rd(OFF_ISTAT, 32'h2);
		$display("test reload done");
		// Capture/compare: idle until the first edge, capture on the second
		wr(OFF_CTL1, {30'h0, MODE_CAPCMP});
		wr(OFF_CTL0, 32'h0);
		wr(OFF_CNTL, 32'h5);
		wr(OFF_RLDH, 32'hff);
		wr(OFF_RLDL, 32'hff);
		wr(OFF_IMASK, 32'h1);
		wr(OFF_ISTAT, 32'h7);
		wr(OFF_CTL1, {24'h0, 1'b1, 5'h0, MODE_CAPCMP});
		cyc(30);
		rd(OFF_CNTL, 32'h5);
		for (i = 0; i < 2; i++) begin
			pin_i.setPin(1'b0);
			cyc(5);
			pin_i.setPin(1'b1);
			cyc(8);
			rd(OFF_ISTAT, {31'h0, i[0]});
		end
		rd(OFF_CTL0, 32'h80);
		cmpIrq(1'b1);
		$display("test capture-compare done");
		// Gated: written start only on the first pass, then source filters
		wr(OFF_CTL1, {30'h0, MODE_GATED});
		pin_i.setPin(1'b0);
		wr(OFF_CNTH, 32'h1);
		wr(OFF_CNTL, 32'h0);
		wr(OFF_RLDH, 32'h1);
		wr(OFF_RLDL, 32'h4);
		wr(OFF_IMASK, 32'h7);
		wr(OFF_ISTAT, 32'h7);
		wr(OFF_CTL1, {24'h0, 1'b1, 5'h0, MODE_GATED});
		pin_i.setPin(1'b1);
		cyc(30);
		pin_i.setPin(1'b0);
		cyc(8);
		rd(OFF_CNTH, 32'h0);
		rd(OFF_ISTAT, 32'h6);
		for (i = 0; i < 2; i++) begin
			wr(OFF_CTL0, {25'h0, cfgs[i], 5'h0});
			wr(OFF_ISTAT, 32'h7);
			pin_i.setPin(1'b1);
			cyc(10);
			pin_i.setPin(1'b0);
			cyc(8);
			rd(OFF_ISTAT, {29'h0, gexp[i]});
		end
		$display("test gated done");
		cyc(4);
		test_done;
	end
endmodule // tb_timer_capture_modes
`default_nettype wire
